// ---- shared/fep_defs.svh ----
// Constants of the flash error and protection block.
// Assumes one 125 MHz clock and 16-bit register words.
// Contract
// R1 - Registers valid only while lock flag low
// R2 - Error flags commit when bank busy clears
// R3 - Bit 0 set on any write/setup error
// R4 - Bit 1 set on erase cell failure
// R5 - Bit 2 set on program cell failure
// R6 - Bit 3 on one-over-zero, not guard bits
// R7 - Bit 6 on invalid setup, no operation
// R8 - Bit 7 on bad resume, operation aborted
// R9 - Bit 8 on protected sector, others proceed
// R10 - Fuses read once at reset into volatiles
// R11 - All protections active until fuses loaded
// R12 - Set-protection refused when running from flash
// R13 - Fuse bits only go one to zero
// R14 - Write guard zero blocks sector writes
// R15 - Access guard blocks non-flash data access
// R16 - Debug guard zero disables test interface
// R17 - Disable fuse zero, reenable one: unguarded
// R18 - Disable fuse 0 needs debug, access zero
// R19 - Disable fuse x needs reenable x-1 zero
// R20 - Reenable zero, next disable one: guarded
// R21 - Reenable fuse x needs disable x zero
// R22 - Temporary unguard bit suspends access guard
// R23 - Denied read gives dummy data, trap
// R24 - Set-protection with ones lifts volatile guard
// R25 - Clear leaves others; set beats clear
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// ****************************************
// Error flag positions
// ****************************************
`define FEP_ERR_WRITE 0
`define FEP_ERR_ERASE 1
`define FEP_ERR_PROG 2
`define FEP_ERR_ONE0 3
`define FEP_ERR_SEQ 6
`define FEP_ERR_RES 7
`define FEP_ERR_GUARD_HIT 8
`define FEP_ERR_MASK 16'h01cf

// ****************************************
// Register indices and fuse layout
// ****************************************
`define FEP_IDX_ERR 3'h0
`define FEP_IDX_WGUARD 3'h1
`define FEP_IDX_ACC 3'h2
`define FEP_IDX_DIS 3'h3
`define FEP_IDX_REN 3'h4
`define FEP_IDX_TEMP 3'h5
`define FEP_NV_WGUARD 2'h0
`define FEP_NV_ACC 2'h1
`define FEP_NV_DIS 2'h2
`define FEP_NV_REN 2'h3
`define FEP_NV_LAST 2'h3
`define FEP_BIT_ACC 0
`define FEP_BIT_DBG 1
`define FEP_NV_ERASED 16'hffff
`define FEP_WORD_ZERO 16'h0000
`define FEP_TRAP_VECTOR 16'h009b

`endif

// ---- shared/fep_pkg.sv ----
// Types of the flash error and protection block.
// Assumes fep_defs.svh supplies the numbers.
package fep_pkg;
    typedef enum logic [1:0] {
        FEP_ST_ISSUE = 2'b00,
        FEP_ST_CAPTURE = 2'b01,
        FEP_ST_RUN = 2'b11
    } fep_state_t;
    typedef logic [1:0] fep_nv_idx_t;
    typedef logic [15:0] fep_word_t;
endpackage : fep_pkg

// ---- shared/fep_nv_if.sv ----
// Link between the protection logic and its fuse cells.
// Assumes one clock; read data arrive one cycle after the read.
interface fep_nv_if;
    logic we;
    logic re;
    fep_pkg::fep_nv_idx_t addr;
    fep_pkg::fep_word_t wdata;
    fep_pkg::fep_word_t rdata;
    modport owner (output we, output re, output addr, output wdata, input rdata);
    modport cells (input we, input re, input addr, input wdata, output rdata);
endinterface : fep_nv_if

// ---- verilog/fep_nv_cells.sv ----
// Four one-time-programmable fuse words with registered read.
// Assumes fuse_por only at power-up; rst leaves the fuses alone.
`include "fep_defs.svh"
module fep_nv_cells
(
    input wire logic clock,
    input wire logic fuse_por,
    fep_nv_if.cells nv
);
    fep_pkg::fep_word_t cell_q [4];
    fep_pkg::fep_word_t rdata_q;

    // Cells only ever lose ones; erased state is all ones
    always_ff @(posedge clock or posedge fuse_por)
    begin
        if (fuse_por)
        begin
            for (int i = 0; i < 4; i++)
                cell_q[i] <= `FEP_NV_ERASED;
        end
        else if (nv.we)
            cell_q[nv.addr] <= cell_q[nv.addr] & nv.wdata; // [R13]
    end

    always_ff @(posedge clock or posedge fuse_por)
    begin
        if (fuse_por)
            rdata_q <= `FEP_WORD_ZERO;
        else if (nv.re)
            rdata_q <= cell_q[nv.addr];
    end

    assign nv.rdata = rdata_q;
endmodule : fep_nv_cells

// ---- verilog/fep_top.sv ----
// Error flags and fuse protection of the embedded flash.
// Assumes a sequencer that reports events and a core on the 16-bit register port.
`include "fep_defs.svh"
module fep_top
(
    input wire logic clock,
    input wire logic rst,
    input wire logic fuse_por,
    input wire logic lock_flag,
    input wire logic bank_busy_flag,
    input wire logic exec_from_flash,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [2:0] reg_idx,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire logic ev_write_err,
    input wire logic ev_erase_fail,
    input wire logic ev_program_fail,
    input wire logic ev_setup_fault,
    input wire logic ev_resume_fault,
    input wire logic prog_check,
    input wire logic [31:0] prog_old,
    input wire logic [31:0] prog_new,
    input wire logic prog_to_guard,
    input wire logic op_start,
    input wire logic [7:0] op_sector_req,
    output logic [7:0] sector_allowed_q,
    output logic resume_abort_q,
    input wire logic setprot_req,
    input wire logic [1:0] setprot_sel,
    input wire logic [15:0] setprot_data,
    input wire logic data_req,
    input wire logic data_wr,
    output logic data_denied_q,
    output logic [15:0] data_dummy_q,
    output logic sw_trap_q,
    output logic [15:0] trap_vector_q,
    output logic test_if_enable_q,
    output logic guards_loaded_q
);
    fep_nv_if nv ();

    fep_nv_cells u_cells
    (
        .clock(clock),
        .fuse_por(fuse_por),
        .nv(nv)
    );

    // ****************************************
    // Fuse bit that may be cleared now
    // ****************************************
    function automatic logic [15:0] fep_clear_ok(input logic [1:0] sel,
                                                 input logic [15:0] acc,
                                                 input logic [15:0] dis,
                                                 input logic [15:0] ren);
        logic [15:0] ok;
        ok = `FEP_NV_ERASED;
        if (sel == `FEP_NV_DIS)
        begin
            ok[0] = ~acc[`FEP_BIT_ACC] & ~acc[`FEP_BIT_DBG]; // [R18]
            ok[15:1] = ~ren[14:0]; // [R19]
        end
        else if (sel == `FEP_NV_REN)
            ok = ~dis; // [R21]
        return ok;
    endfunction : fep_clear_ok

    fep_pkg::fep_state_t state_q;
    fep_pkg::fep_state_t state_d;
    logic [1:0] load_idx_q;
    logic [15:0] wguard_vol_q;
    logic [15:0] wguard_nv_q;
    logic [15:0] acc_vol_q;
    logic [15:0] dis_vol_q;
    logic [15:0] ren_vol_q;
    logic temp_unguard_q;
    logic [15:0] err_q;
    logic [15:0] err_d;
    logic [15:0] pend_q;
    logic [15:0] pend_d;

    // ****************************************
    // Fuse load after reset
    // ****************************************
    wire loaded = (state_q == fep_pkg::FEP_ST_RUN);
    wire load_last = (load_idx_q == `FEP_NV_LAST);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            fep_pkg::FEP_ST_ISSUE: state_d = fep_pkg::FEP_ST_CAPTURE;
            fep_pkg::FEP_ST_CAPTURE:
                state_d = load_last ? fep_pkg::FEP_ST_RUN : fep_pkg::FEP_ST_ISSUE;
            default: state_d = fep_pkg::FEP_ST_RUN;
        endcase
    end

    // ****************************************
    // Protection decisions
    // ****************************************
    logic [15:0] chain_open;
    always_comb
    begin
        for (int x = 0; x < 16; x++)
        begin
            // Disable x with reenable x intact means unguarded; the next pair
            // only matters once reenable x is blown
            chain_open[x] = ~dis_vol_q[x] & ren_vol_q[x]; // [R17] [R20]
        end
    end
    wire guard_off = |chain_open;
    wire acc_guard = ~loaded // [R11]
        | (~acc_vol_q[`FEP_BIT_ACC] & ~temp_unguard_q & ~guard_off); // [R22]
    wire access_blocked = acc_guard & ~exec_from_flash; // [R15]
    wire [7:0] sector_open = loaded ? wguard_vol_q[7:0] : 8'h00; // [R11] [R14]
    wire debug_open = loaded & acc_vol_q[`FEP_BIT_DBG]; // [R16]

    // ****************************************
    // Set-protection operation
    // ****************************************
    wire sp_go = setprot_req & loaded & ~exec_from_flash; // [R12]
    wire sp_from_flash = setprot_req & exec_from_flash; // [R12]
    wire [15:0] sp_cur = (setprot_sel == `FEP_NV_WGUARD) ? wguard_nv_q :
                         (setprot_sel == `FEP_NV_ACC) ? acc_vol_q :
                         (setprot_sel == `FEP_NV_DIS) ? dis_vol_q : ren_vol_q;
    wire [15:0] sp_ok = fep_clear_ok(setprot_sel, acc_vol_q, dis_vol_q, ren_vol_q);
    wire [15:0] sp_want = ~setprot_data & sp_cur;
    wire [15:0] sp_refused = sp_want & ~sp_ok;
    wire [15:0] sp_new = sp_cur & ~(sp_want & sp_ok); // [R13]
    wire sp_fault = sp_from_flash | (sp_go & |sp_refused);

    // ****************************************
    // Error events
    // ****************************************
    wire one_over_zero = prog_check & ~prog_to_guard & |(prog_new & ~prog_old); // [R6]
    wire wp_hit = op_start & loaded & |(op_sector_req & ~sector_open); // [R9]
    wire wp_hit_early = op_start & ~loaded & |op_sector_req; // [R11]
    logic [15:0] ev_now;
    always_comb
    begin
        ev_now = `FEP_WORD_ZERO;
        ev_now[`FEP_ERR_ERASE] = ev_erase_fail; // [R4]
        ev_now[`FEP_ERR_PROG] = ev_program_fail; // [R5]
        ev_now[`FEP_ERR_ONE0] = one_over_zero; // [R6]
        ev_now[`FEP_ERR_SEQ] = ev_setup_fault | sp_fault; // [R7]
        ev_now[`FEP_ERR_RES] = ev_resume_fault; // [R8]
        ev_now[`FEP_ERR_GUARD_HIT] = wp_hit | wp_hit_early; // [R9]
        ev_now[`FEP_ERR_WRITE] = ev_write_err | (|ev_now); // [R3]
    end

    // Flags gather while busy and land together when busy drops
    wire commit = ~bank_busy_flag; // [R2]
    wire [15:0] err_set = commit ? (pend_q | ev_now) : `FEP_WORD_ZERO;
    assign pend_d = commit ? `FEP_WORD_ZERO : (pend_q | ev_now);

    // ****************************************
    // Register port
    // ****************************************
    wire reg_ok = ~lock_flag & ~access_blocked; // [R1]
    // Guarded flash refuses register writes; the unguard bit is the way back
    wire wr_ok = reg_wr & ~lock_flag & ~acc_guard;
    wire wr_err = wr_ok & (reg_idx == `FEP_IDX_ERR);
    wire wr_temp = reg_wr & ~lock_flag & exec_from_flash & (reg_idx == `FEP_IDX_TEMP);
    wire [15:0] err_clr = wr_err ? (reg_wdata & `FEP_ERR_MASK) : `FEP_WORD_ZERO;
    assign err_d = ((err_q & ~err_clr) | err_set) & `FEP_ERR_MASK; // [R25]

    logic [15:0] rd_word;
    always_comb
    begin
        if (reg_idx == `FEP_IDX_ERR)
            rd_word = err_q;
        else if (reg_idx == `FEP_IDX_WGUARD)
            rd_word = wguard_nv_q;
        else if (reg_idx == `FEP_IDX_ACC)
            rd_word = acc_vol_q;
        else if (reg_idx == `FEP_IDX_DIS)
            rd_word = dis_vol_q;
        else if (reg_idx == `FEP_IDX_REN)
            rd_word = ren_vol_q;
        else if (reg_idx == `FEP_IDX_TEMP)
            rd_word = {15'h0000, temp_unguard_q};
        else
            rd_word = `FEP_WORD_ZERO;
    end

    // ****************************************
    // Fuse cell port
    // ****************************************
    assign nv.re = (state_q == fep_pkg::FEP_ST_ISSUE);
    assign nv.we = sp_go;
    assign nv.addr = sp_go ? setprot_sel : load_idx_q;
    assign nv.wdata = sp_new;

    // ****************************************
    // State
    // ****************************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= fep_pkg::FEP_ST_ISSUE;
            load_idx_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == fep_pkg::FEP_ST_CAPTURE)
                load_idx_q <= load_idx_q + 2'h1;
        end
    end

    // Volatile copies; guard words reset to zero, disable and reenable words to all ones: guarded, the safe value before the load
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wguard_vol_q <= `FEP_WORD_ZERO;
            wguard_nv_q <= `FEP_WORD_ZERO;
            acc_vol_q <= `FEP_WORD_ZERO;
            dis_vol_q <= `FEP_NV_ERASED;
            ren_vol_q <= `FEP_NV_ERASED;
        end
        else if (state_q == fep_pkg::FEP_ST_CAPTURE)
        begin
            if (load_idx_q == `FEP_NV_WGUARD)
            begin
                wguard_vol_q <= nv.rdata; // [R10]
                wguard_nv_q <= nv.rdata;
            end
            else if (load_idx_q == `FEP_NV_ACC)
                acc_vol_q <= nv.rdata; // [R10]
            else if (load_idx_q == `FEP_NV_DIS)
                dis_vol_q <= nv.rdata; // [R10]
            else
                ren_vol_q <= nv.rdata; // [R10]
        end
        else if (sp_go)
        begin
            if (setprot_sel == `FEP_NV_WGUARD)
            begin
                // Ones lift the guard only here; the cells keep their zeros
                wguard_vol_q <= setprot_data; // [R24]
                wguard_nv_q <= sp_new;
            end
            else if (setprot_sel == `FEP_NV_ACC)
                acc_vol_q <= sp_new;
            else if (setprot_sel == `FEP_NV_DIS)
                dis_vol_q <= sp_new;
            else
                ren_vol_q <= sp_new;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            err_q <= `FEP_WORD_ZERO;
            pend_q <= `FEP_WORD_ZERO;
            temp_unguard_q <= 1'b0;
        end
        else
        begin
            err_q <= err_d;
            pend_q <= pend_d;
            if (wr_temp)
                temp_unguard_q <= reg_wdata[0]; // [R22]
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata_q <= `FEP_WORD_ZERO;
            reg_rvalid_q <= 1'b0;
            sector_allowed_q <= 8'h00;
            resume_abort_q <= 1'b0;
            data_denied_q <= 1'b0;
            data_dummy_q <= `FEP_WORD_ZERO;
            sw_trap_q <= 1'b0;
            trap_vector_q <= `FEP_WORD_ZERO;
            test_if_enable_q <= 1'b0;
            guards_loaded_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd & reg_ok; // [R1]
            reg_rdata_q <= (reg_rd & reg_ok) ? rd_word : `FEP_WORD_ZERO; // [R1]
            if (op_start)
                sector_allowed_q <= op_sector_req & sector_open; // [R9] [R14]
            resume_abort_q <= ev_resume_fault; // [R8]
            data_denied_q <= data_req & access_blocked; // [R15]
            data_dummy_q <= `FEP_WORD_ZERO; // [R23]
            sw_trap_q <= data_req & ~data_wr & access_blocked; // [R23]
            trap_vector_q <= (data_req & ~data_wr & access_blocked) ?
                             `FEP_TRAP_VECTOR : `FEP_WORD_ZERO; // [R23]
            test_if_enable_q <= debug_open; // [R16]
            guards_loaded_q <= loaded;
        end
    end
endmodule : fep_top

// ---- sim/fep_top_checker.sv ----
// Concurrent checks on the ports of the flash error and protection top.
// Assumes it is bound into fep_top; one clock, rst asynchronous.
`include "fep_defs.svh"
module fep_top_checker
(
    input wire logic clock,
    input wire logic rst,
    input wire logic lock_flag,
    input wire logic reg_rd,
    input wire logic reg_rvalid_q,
    input wire logic [15:0] reg_rdata_q,
    input wire logic ev_resume_fault,
    input wire logic resume_abort_q,
    input wire logic data_req,
    input wire logic data_wr,
    input wire logic exec_from_flash,
    input wire logic data_denied_q,
    input wire logic sw_trap_q,
    input wire logic [15:0] trap_vector_q,
    input wire logic [15:0] data_dummy_q,
    input wire logic op_start,
    input wire logic [7:0] op_sector_req,
    input wire logic [7:0] sector_allowed_q,
    input wire logic guards_loaded_q,
    input wire logic test_if_enable_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Port relations
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    read_answer_a: assert property (reg_rvalid_q |-> $past(reg_rd) && !$past(lock_flag))
        else $error("read answered without a request");
    lock_refuse_a: assert property (reg_rd && lock_flag |=> !reg_rvalid_q)
        else $error("read answered while locked");
    idle_data_a: assert property (!reg_rvalid_q |-> reg_rdata_q == 16'h0000)
        else $error("read data shown without valid");
    abort_follow_a: assert property (ev_resume_fault |=> resume_abort_q)
        else $error("bad resume not aborted");
    abort_cause_a: assert property (resume_abort_q |-> $past(ev_resume_fault))
        else $error("abort without bad resume");
    trap_vector_a: assert property (sw_trap_q |->
        trap_vector_q == `FEP_TRAP_VECTOR && data_denied_q && !$past(data_wr))
        else $error("trap without denied read");
    dummy_zero_a: assert property (data_dummy_q == 16'h0000)
        else $error("dummy data not zero");
    flash_fetch_a: assert property (data_req && exec_from_flash |=> !data_denied_q)
        else $error("access from flash refused");
    unloaded_guard_a: assert property (!guards_loaded_q |->
        sector_allowed_q == 8'h00 && !test_if_enable_q)
        else $error("guard open before load");
    sector_mask_a: assert property (op_start |=>
        (sector_allowed_q & ~$past(op_sector_req)) == 8'h00)
        else $error("unrequested sector allowed");
    sector_hold_a: assert property (!op_start |=> $stable(sector_allowed_q))
        else $error("sector grant moved without start");
    cover property (sw_trap_q);
    cover property (resume_abort_q);
    cover property (op_start ##1 sector_allowed_q != 8'h00);
endmodule : fep_top_checker

bind fep_top fep_top_checker i_chk (.clock(clock), .rst(rst), .lock_flag(lock_flag),
    .reg_rd(reg_rd), .reg_rvalid_q(reg_rvalid_q), .reg_rdata_q(reg_rdata_q),
    .ev_resume_fault(ev_resume_fault), .resume_abort_q(resume_abort_q),
    .data_req(data_req), .data_wr(data_wr), .exec_from_flash(exec_from_flash),
    .data_denied_q(data_denied_q), .sw_trap_q(sw_trap_q), .trap_vector_q(trap_vector_q),
    .data_dummy_q(data_dummy_q), .op_start(op_start), .op_sector_req(op_sector_req),
    .sector_allowed_q(sector_allowed_q), .guards_loaded_q(guards_loaded_q),
    .test_if_enable_q(test_if_enable_q));

// ---- sim/fep_core_model.sv ----
// Core model issuing 16-bit register reads and writes.
// Assumes requests start at a falling edge and are taken at the next rise.
module fep_core_model
(
    input wire logic clock,
    input wire logic [15:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    output logic reg_rd,
    output logic reg_wr,
    output logic [2:0] reg_idx,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Bus tasks
    // ****************************************
    initial
    begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_idx = 3'h7;
        reg_wdata = 16'h5a5a;
    end
    // Released lines show the inverse so stale values never match
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_idx = idx;
        reg_wdata = d; // Flag clears are write-one words
        @(negedge clock);
        reg_wr = 1'b0;
        reg_idx = ~idx;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [2:0] idx, output logic [16:0] got);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_idx = idx;
        @(negedge clock);
        got = {reg_rvalid_q, reg_rdata_q};
        reg_rd = 1'b0;
        reg_idx = ~idx;
    endtask : rd
endmodule : fep_core_model

// ---- sim/flash_error_and_protection_tb_top.sv ----
// Self-checking bench for the flash error and protection top.
// Assumes fuse cells erased at power-up and a 125 MHz clock.
module flash_error_and_protection_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, fuse_por, lock_flag, bank_busy_flag, exec_from_flash;
    logic reg_rd, reg_wr, reg_rvalid_q, prog_check, prog_to_guard, op_start, setprot_req;
    logic data_req, data_wr, data_denied_q, sw_trap_q, test_if_enable_q, guards_loaded_q;
    logic resume_abort_q;
    logic [1:0] setprot_sel;
    logic [2:0] reg_idx;
    logic [4:0] ev;
    logic [7:0] op_sector_req, sector_allowed_q;
    logic [15:0] reg_wdata, reg_rdata_q, setprot_data, data_dummy_q, trap_vector_q;
    logic [31:0] prog_old, prog_new;
    int n_errors, samples_checked;
    fep_top i_dut (.clock(clock), .rst(rst), .fuse_por(fuse_por), .lock_flag(lock_flag),
        .bank_busy_flag(bank_busy_flag), .exec_from_flash(exec_from_flash),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .ev_write_err(ev[0]),
        .ev_erase_fail(ev[1]), .ev_program_fail(ev[2]), .ev_setup_fault(ev[3]),
        .ev_resume_fault(ev[4]), .prog_check(prog_check), .prog_old(prog_old),
        .prog_new(prog_new), .prog_to_guard(prog_to_guard), .op_start(op_start),
        .op_sector_req(op_sector_req), .sector_allowed_q(sector_allowed_q),
        .resume_abort_q(resume_abort_q), .setprot_req(setprot_req),
        .setprot_sel(setprot_sel), .setprot_data(setprot_data), .data_req(data_req),
        .data_wr(data_wr), .data_denied_q(data_denied_q), .data_dummy_q(data_dummy_q),
        .sw_trap_q(sw_trap_q), .trap_vector_q(trap_vector_q),
        .test_if_enable_q(test_if_enable_q), .guards_loaded_q(guards_loaded_q));
    fep_core_model i_core (.clock(clock), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdc(input logic [2:0] idx, input logic [16:0] exp);
        logic [16:0] got;
        i_core.rd(idx, got);
        chk("register read", exp, got);
    endtask : rdc
    task automatic pulse(input logic [4:0] m);
        @(negedge clock);
        ev = m;
        @(negedge clock);
        ev = 5'h00;
    endtask : pulse
    task automatic pc(input logic g);
        @(negedge clock);
        prog_check = 1'b1;
        prog_to_guard = g;
        @(negedge clock);
        prog_check = 1'b0;
    endtask : pc
    task automatic sp(input logic [1:0] s, input logic [15:0] d);
        @(negedge clock);
        setprot_req = 1'b1;
        setprot_sel = s;
        setprot_data = d;
        @(negedge clock);
        setprot_req = 1'b0;
        setprot_data = ~d;
        repeat (2) @(negedge clock);
    endtask : sp
    task automatic op(input logic [7:0] req, input logic [7:0] exp);
        @(negedge clock);
        op_start = 1'b1;
        op_sector_req = req;
        @(negedge clock);
        op_start = 1'b0;
        chk("sectors allowed", {9'h0, exp}, {9'h0, sector_allowed_q});
    endtask : op
    task automatic dacc(input logic w, input logic [1:0] exp);
        @(negedge clock);
        data_req = 1'b1;
        data_wr = w;
        @(negedge clock);
        data_req = 1'b0;
        chk("data access", {15'h0, exp}, {15'h0, data_denied_q, sw_trap_q});
    endtask : dacc
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        int n;
        repeat (3) @(negedge clock);
        fuse_por = 1'b0;
        rst = 1'b0;
        n = 0;
        chk("loaded at release", 17'h0, {16'h0, guards_loaded_q});
        while (guards_loaded_q !== 1'b1 && n < 50)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("load edges", 17'h9, 17'(n));
        chk("test interface", 17'h1, {16'h0, test_if_enable_q});
        rdc(3'h2, 17'h1ffff);
        lock_flag = 1'b1;
        rdc(3'h0, 17'h0);
        lock_flag = 1'b0;
    endtask : t_reset
    task automatic t_errors();
        logic [15:0] exp [5] = '{16'h0001, 16'h0003, 16'h0005, 16'h0041, 16'h0081};
        bank_busy_flag = 1'b1;
        pulse(5'h02);
        rdc(3'h0, 17'h10000);
        bank_busy_flag = 1'b0;
        repeat (2) @(negedge clock);
        rdc(3'h0, 17'h10003);
        i_core.wr(3'h0, 16'h0002);
        rdc(3'h0, 17'h10001);
        // Clear and hardware set on the same edge: the set must survive
        fork
            i_core.wr(3'h0, 16'hffff);
            pulse(5'h04);
        join
        rdc(3'h0, 17'h10005);
        i_core.wr(3'h0, 16'hffff);
        for (int i = 0; i < 5; i++)
        begin
            pulse(5'(1 << i));
            rdc(3'h0, {1'b1, exp[i]});
            i_core.wr(3'h0, 16'hffff);
        end
        pc(1'b0);
        rdc(3'h0, 17'h10009);
        i_core.wr(3'h0, 16'hffff);
        pc(1'b1);
        rdc(3'h0, 17'h10000);
    endtask : t_errors
    task automatic t_wguard();
        sp(2'h0, 16'hfffe);
        op(8'h03, 8'h02);
        rdc(3'h0, 17'h10101);
        rdc(3'h1, 17'h1fffe);
        i_core.wr(3'h0, 16'hffff);
        sp(2'h0, 16'hffff);
        op(8'h03, 8'h03);
        rdc(3'h1, 17'h1fffe);
        exec_from_flash = 1'b1;
        sp(2'h0, 16'h0000);
        exec_from_flash = 1'b0;
        rdc(3'h0, 17'h10041);
        op(8'hff, 8'hff);
        i_core.wr(3'h0, 16'hffff);
        sp(2'h2, 16'hfffe);
        rdc(3'h0, 17'h10041);
        rdc(3'h3, 17'h1ffff);
        i_core.wr(3'h0, 16'hffff);
    endtask : t_wguard
    task automatic t_access();
        sp(2'h1, 16'hfffc);
        chk("test interface", 17'h0, {16'h0, test_if_enable_q});
        dacc(1'b0, 2'b11);
        dacc(1'b1, 2'b10);
        rdc(3'h0, 17'h0);
        exec_from_flash = 1'b1;
        i_core.wr(3'h5, 16'h0001);
        exec_from_flash = 1'b0;
        dacc(1'b0, 2'b00);
        rdc(3'h5, 17'h10001);
        rdc(3'h7, 17'h10000);
        exec_from_flash = 1'b1;
        i_core.wr(3'h5, 16'h0000);
        exec_from_flash = 1'b0;
        dacc(1'b0, 2'b11);
        sp(2'h2, 16'hfffe);
        dacc(1'b0, 2'b00);
        sp(2'h3, 16'hfffd);
        rdc(3'h4, 17'h1ffff);
        rdc(3'h0, 17'h10041);
        i_core.wr(3'h0, 16'hffff);
        sp(2'h3, 16'hfffe);
        dacc(1'b0, 2'b11);
        sp(2'h2, 16'hfffa);
        exec_from_flash = 1'b1;
        rdc(3'h3, 17'h1fffe);
        rdc(3'h0, 17'h10041);
        exec_from_flash = 1'b0;
    endtask : t_access
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
    initial
    begin
        {rst, fuse_por, lock_flag, bank_busy_flag, exec_from_flash} = 5'h18;
        {prog_check, prog_to_guard, op_start, setprot_req, data_req, data_wr} = 6'h00;
        {ev, setprot_sel, op_sector_req, setprot_data} = 31'h0;
        prog_old = 32'h0000_0000;
        prog_new = 32'h0000_0001;
        n_errors = 0;
        samples_checked = 0;
        t_reset();
        t_errors();
        t_wguard();
        t_access();
        conclude();
    end
endmodule : flash_error_and_protection_tb_top
